// [rtl/ssil_pkg.sv]
package ssil_pkg;
	// ==========================================================
	// Timing
	localparam int CLK_KHZ = 250000;
	localparam int WIN_MS = 100;
	localparam int WIN_CYC = WIN_MS * CLK_KHZ;
	localparam int UNST_MIN_MS = 100;
	localparam int UNST_MIN_CYC = UNST_MIN_MS * CLK_KHZ;
	localparam int OFF_MS = 20;
	localparam int OFF_CYC = OFF_MS * CLK_KHZ;
	localparam int STEP_MS = 50;
	localparam int STEP_CYC = STEP_MS * CLK_KHZ;
	localparam int TMR_W = 25;
	localparam int DIM_W = 2;
	// ==========================================================
	// Sizes
	localparam int SIG_W = 16;
	localparam int REF_W = 8;
	localparam int DEPTH = 32;
	localparam int NSEG = 40;
	// ==========================================================
	// Register offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STAT = 8'h04;
	localparam logic [7:0] OFF_DISP = 8'h08;
	localparam logic [7:0] OFF_COMP = 8'h0c;
	// ==========================================================
	// Control fields
	localparam int CB_RECALL = 0;
	localparam int CB_EDIT = 1;
	localparam int CB_HOLD = 2;
	localparam int CB_ULATCH = 3;
	localparam int CB_AUTOLOG = 4;
	localparam int CB_SRQMASK = 5;
	localparam int CB_CLEAR = 8;
	localparam logic [5:0] CTRL_RST = 6'h00;
	// ==========================================================
	// Status fields
	localparam int SB_UNST = 0;
	localparam int SB_COMP = 1;
	localparam int SB_DEPTH = 8;
	localparam int SB_REF = 16;
	localparam logic [1:0] RESP_OK = 2'b00;
	localparam logic [1:0] RESP_ERR = 2'b10;
	// Trigger sequencing
	typedef enum logic [1:0] {TR_IDLE, TR_ARMED, TR_MEAS} ssil_trig_t;
endpackage

// [rtl/ssil_probe_if.sv]
`timescale 1ns/1ps
// ==========================================================
// Probe indicator link between sequencer and lamp driver
interface ssil_probe_if;
	logic tip_hi;
	logic tip_lo;
	logic busy;
	logic off_req;
	logic suspend;
	logic led;
	modport ctrl (output tip_hi, output tip_lo, output busy, output off_req, output suspend, input led);
	modport ind (input tip_hi, input tip_lo, input busy, input off_req, input suspend, output led);
endinterface

// [rtl/ssil_probe_ind.sv]
`timescale 1ns/1ps
// ==========================================================
// Probe tip logic lamp: bright, off, dim or blinking
module ssil_probe_ind #(
	parameter int WIN_CYC = ssil_pkg::WIN_CYC,
	parameter int OFF_CYC = ssil_pkg::OFF_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	ssil_probe_if.ind pif
);
	typedef struct packed {
		logic [ssil_pkg::TMR_W-1:0] win;
		logic [ssil_pkg::TMR_W-1:0] off;
		logic seen_hi;
		logic seen_lo;
		logic [1:0] mode;
		logic blink;
		logic [ssil_pkg::DIM_W-1:0] pwm;
		logic led;
	} ssil_pi_t;
	ssil_pi_t s_r, s_nxt;

	// Modes: 0 off, 1 bright, 2 dim, 3 blink
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.pwm = s_r.pwm + 1'b1;
		s_nxt.seen_hi = s_r.seen_hi | pif.tip_hi; // [R7]
		s_nxt.seen_lo = s_r.seen_lo | pif.tip_lo;
		if (s_r.win == '0)
		begin
			s_nxt.win = ssil_pkg::TMR_W'(WIN_CYC - 1);
			s_nxt.seen_hi = pif.tip_hi;
			s_nxt.seen_lo = pif.tip_lo;
			s_nxt.blink = ~s_r.blink; // [R9]
			case ({s_r.seen_hi, s_r.seen_lo})
				2'b00: s_nxt.mode = 2'd2; // [R8]
				2'b11: s_nxt.mode = 2'd3; // [R9]
				2'b10: s_nxt.mode = 2'd1; // [R10]
				default: s_nxt.mode = 2'd0; // [R10]
			endcase
		end
		else
			s_nxt.win = s_r.win - 1'b1;
		if (pif.off_req)
			s_nxt.off = ssil_pkg::TMR_W'(OFF_CYC - 1);
		else if (s_r.off != '0)
			s_nxt.off = s_r.off - 1'b1;
		// Measurement overrides logic indication, then a short dark gap
		if (pif.suspend)
			s_nxt.led = 1'b0;
		else if (pif.busy)
			s_nxt.led = 1'b1; // [R11]
		else if (pif.off_req || s_r.off != '0)
			s_nxt.led = 1'b0; // [R11]
		else
			case (s_r.mode)
				2'd1: s_nxt.led = 1'b1;
				2'd2: s_nxt.led = (s_r.pwm == '0); // Quarter duty reads as dim
				2'd3: s_nxt.led = s_r.blink;
				default: s_nxt.led = 1'b0;
			endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s_r <= '0;
		else if (ce)
			s_r <= s_nxt;
	end

	assign pif.led = s_r.led;
endmodule // ssil_probe_ind

// [rtl/ssil_top.sv]
// The register offsets and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
// Contract
// R1: Composite lamp lights only while the composite sum is shown, only in review.
// R2: Composite display also lights all four decimal points.
// R3: A signature is stable only when two consecutive gate cycles agree.
// R4: Unstable lamp sets when a new signature differs from the previous one.
// R5: Unlatched, unstable clears after a matching pair and at least 100ms.
// R6: With unstable latch on, unstable holds until a clear.
// R7: Outside measurement and self-test, tip levels are sampled in ~100ms windows.
// R8: A window with neither level gives a dim lamp.
// R9: A window with both levels blinks the lamp.
// R10: Only highs give bright lamp; only lows give lamp off.
// R11: Lamp bright during triggered measurement, then briefly off.
// R12: Remote can never disable the probe switch.
// R13: Normal mode: press marks next measurement triggered; push and add to sum.
// R14: Only triggered signatures enter the stack and the composite sum.
// R15: Hold mode updates display only on triggered completion.
// R16: Review mode: press steps one entry older instead of measuring.
// R17: Edit alone: triggered result replaces newest entry, sum recomputed.
// R18: Edit in review: result replaces shown entry, keeps its slot and number.
// R19: Self-test press runs a lamp and segment walk, then returns.
// R20: Remote: result offered, optional logic report, press may request service.
// R21: Thirty-two entry push-down stack, oldest dropped when full.
// R22: Reference numbers start at 1, increment, shown as two low digits.
// R23: Composite is the running binary sum of triggered signatures.
// R24: Clear blanks display, zeroes sum and stack, drops unstable, aborts measuring.
// R25: Reference counter is decimal modulo one hundred, stored with each entry.
// R26: The composite entry cannot be edited; such an edit changes nothing.
module ssil_top #(
	parameter int WIN_CYC = ssil_pkg::WIN_CYC,
	parameter int UNST_CYC = ssil_pkg::UNST_MIN_CYC,
	parameter int OFF_CYC = ssil_pkg::OFF_CYC,
	parameter int STEP_CYC = ssil_pkg::STEP_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic gate_start,
	input wire logic sig_done,
	input wire logic [ssil_pkg::SIG_W-1:0] sig_value,
	input wire logic probe_press,
	input wire logic clear_key,
	input wire logic self_test,
	input wire logic remote,
	input wire logic tip_high,
	input wire logic tip_low,
	output logic [ssil_pkg::SIG_W-1:0] disp_sig,
	output logic [ssil_pkg::REF_W-1:0] disp_ref,
	output logic disp_ref_on,
	output logic [3:0] disp_dp,
	output logic composite_led,
	output logic unstable_led,
	output logic probe_led,
	output logic seg_walk,
	output logic [5:0] seg_walk_idx,
	output logic sig_offer,
	output logic logic_report,
	output logic srq
);
	localparam int EW = ssil_pkg::SIG_W + ssil_pkg::REF_W;

	typedef struct packed {
		ssil_pkg::ssil_trig_t trig;
		logic [ssil_pkg::SIG_W-1:0] prev;
		logic prev_ok;
		logic unst;
		logic matched;
		logic [ssil_pkg::TMR_W-1:0] utmr;
		logic [ssil_pkg::DEPTH-1:0][EW-1:0] mem;
		logic [4:0] head;
		logic [5:0] depth;
		logic [ssil_pkg::REF_W-1:0] refc;
		logic [5:0] pos;
		logic [ssil_pkg::SIG_W-1:0] comp;
		logic [ssil_pkg::SIG_W-1:0] live;
		logic [5:0] ctrl;
		logic walk;
		logic [5:0] widx;
		logic [ssil_pkg::TMR_W-1:0] wtmr;
		logic busy;
		logic off_req;
		logic offer;
		logic report;
		logic srq;
		logic aw_got;
		logic [7:0] aw_addr;
		logic w_got;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [ssil_pkg::SIG_W-1:0] dsig;
		logic [ssil_pkg::REF_W-1:0] dref;
		logic dref_on;
		logic [3:0] dp;
		logic cled;
	} ssil_st_t;
	ssil_st_t s_r, s_nxt;

	ssil_probe_if pif ();

	// ==========================================================
	// Helpers
	// Two-digit decimal increment wrapping 99 to 00
	function automatic logic [7:0] ssil_bcd_inc(input logic [7:0] v);
		logic [7:0] r;
		r = v;
		if (v[3:0] == 4'h9)
		begin
			r[3:0] = 4'h0;
			r[7:4] = (v[7:4] == 4'h9) ? 4'h0 : v[7:4] + 4'h1;
		end
		else
			r[3:0] = v[3:0] + 4'h1;
		return r;
	endfunction

	// Stack slot holding review position k (1 = newest)
	function automatic logic [4:0] ssil_slot(input logic [4:0] head, input logic [5:0] k);
		return head - 5'(k - 6'd1);
	endfunction

	// ==========================================================
	// Next-state logic
	always_comb
	begin
		logic clr;
		logic wr_go;
		logic recall;
		logic edit;
		logic [4:0] slot;
		logic [ssil_pkg::SIG_W-1:0] old;
		clr = 1'b0;
		wr_go = 1'b0;
		recall = 1'b0;
		edit = 1'b0;
		slot = '0;
		old = '0;
		s_nxt = s_r;
		s_nxt.off_req = 1'b0;
		s_nxt.offer = 1'b0;
		s_nxt.report = 1'b0;
		s_nxt.srq = 1'b0;

		// AXI write: address and data taken in either order
		if (s_axi_awvalid && s_r.awready)
		begin
			s_nxt.aw_got = 1'b1;
			s_nxt.aw_addr = s_axi_awaddr[7:0];
		end
		if (s_axi_wvalid && s_r.wready)
		begin
			s_nxt.w_got = 1'b1;
			s_nxt.wdata = s_axi_wdata;
			s_nxt.wstrb = s_axi_wstrb;
		end
		if (s_r.aw_got && s_r.w_got && !s_r.bvalid)
		begin
			wr_go = 1'b1;
			s_nxt.aw_got = 1'b0;
			s_nxt.w_got = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = ssil_pkg::RESP_OK;
			if (s_r.aw_addr == ssil_pkg::OFF_CTRL)
			begin
				if (s_r.wstrb[0])
					s_nxt.ctrl = s_r.wdata[5:0];
				clr = s_r.wstrb[1] && s_r.wdata[ssil_pkg::CB_CLEAR];
			end
			else if (s_r.aw_addr != ssil_pkg::OFF_STAT && s_r.aw_addr != ssil_pkg::OFF_DISP
				&& s_r.aw_addr != ssil_pkg::OFF_COMP)
				s_nxt.bresp = ssil_pkg::RESP_ERR;
		end
		if (s_r.bvalid && s_axi_bready)
			s_nxt.bvalid = 1'b0;
		s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
		s_nxt.wready = !s_nxt.w_got && !s_nxt.bvalid;

		// AXI read: one at a time, answered the cycle after the address
		if (s_axi_arvalid && s_r.arready)
		begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = ssil_pkg::RESP_OK;
			case (s_axi_araddr[7:0])
				ssil_pkg::OFF_CTRL: s_nxt.rdata = {26'h0, s_r.ctrl};
				ssil_pkg::OFF_STAT: s_nxt.rdata = {8'h0, s_r.refc, 2'h0, s_r.depth, 6'h0, s_r.cled, s_r.unst};
				ssil_pkg::OFF_DISP: s_nxt.rdata = {8'h0, s_r.dref, s_r.dsig};
				ssil_pkg::OFF_COMP: s_nxt.rdata = {16'h0, s_r.comp};
				default:
				begin
					s_nxt.rdata = 32'h0;
					s_nxt.rresp = ssil_pkg::RESP_ERR;
				end
			endcase
		end
		else if (s_r.rvalid && s_axi_rready)
			s_nxt.rvalid = 1'b0;
		s_nxt.arready = !s_nxt.rvalid;

		clr = clr || clear_key;
		recall = s_r.ctrl[ssil_pkg::CB_RECALL];
		edit = s_r.ctrl[ssil_pkg::CB_EDIT];

		// Probe switch: never masked by remote, only the mode decides [R12]
		if (probe_press)
		begin
			if (remote && s_r.ctrl[ssil_pkg::CB_SRQMASK])
				s_nxt.srq = 1'b1; // [R20]
			if (self_test)
			begin
				s_nxt.walk = 1'b1; // [R19]
				s_nxt.widx = '0;
				s_nxt.wtmr = ssil_pkg::TMR_W'(STEP_CYC - 1);
			end
			else if (recall && !edit)
				s_nxt.pos = (s_r.pos >= s_r.depth) ? 6'd0 : s_r.pos + 6'd1; // [R16]
			else if (s_r.trig == ssil_pkg::TR_IDLE)
				s_nxt.trig = ssil_pkg::TR_ARMED; // [R13]
		end

		// Segment walk steps through every lamp, then hands back
		if (s_r.walk)
		begin
			if (s_r.wtmr != '0)
				s_nxt.wtmr = s_r.wtmr - 1'b1;
			else if (s_r.widx == 6'(ssil_pkg::NSEG - 1))
				s_nxt.walk = 1'b0; // [R19]
			else
			begin
				s_nxt.widx = s_r.widx + 6'd1;
				s_nxt.wtmr = ssil_pkg::TMR_W'(STEP_CYC - 1);
			end
		end

		// The next gate to open after a press is the triggered one
		if (gate_start && s_r.trig == ssil_pkg::TR_ARMED)
		begin
			s_nxt.trig = ssil_pkg::TR_MEAS; // [R13]
			s_nxt.busy = 1'b1; // [R11]
		end

		// Instability watch runs on every signature, triggered or not
		if (s_r.utmr != '0)
			s_nxt.utmr = s_r.utmr - 1'b1;
		if (sig_done)
		begin
			s_nxt.prev = sig_value;
			s_nxt.prev_ok = 1'b1;
			if (s_r.prev_ok && sig_value != s_r.prev)
			begin
				s_nxt.unst = 1'b1; // [R4]
				s_nxt.matched = 1'b0;
				s_nxt.utmr = ssil_pkg::TMR_W'(UNST_CYC - 1);
			end
			else if (s_r.prev_ok)
				s_nxt.matched = 1'b1; // [R3]
			if (!(s_r.ctrl[ssil_pkg::CB_HOLD]))
				s_nxt.live = sig_value;
		end
		// Both the matching pair and the minimum on-time are needed
		if (s_r.unst && s_r.matched && s_r.utmr == '0 && !s_r.ctrl[ssil_pkg::CB_ULATCH])
			s_nxt.unst = 1'b0; // [R5] [R6]

		// Triggered completion: the only path into stack and sum [R14]
		if (sig_done && s_r.trig == ssil_pkg::TR_MEAS)
		begin
			s_nxt.trig = ssil_pkg::TR_IDLE;
			s_nxt.busy = 1'b0;
			s_nxt.off_req = 1'b1; // [R11]
			s_nxt.live = sig_value; // [R15]
			if (remote)
			begin
				s_nxt.offer = 1'b1; // [R20]
				s_nxt.report = s_r.ctrl[ssil_pkg::CB_AUTOLOG];
			end
			if (!edit)
			begin
				s_nxt.head = (s_r.depth == 6'd0) ? s_r.head : s_r.head + 5'd1; // [R21]
				s_nxt.refc = ssil_bcd_inc(s_r.refc); // [R22] [R25]
				s_nxt.mem[s_nxt.head] = {s_nxt.refc, sig_value};
				if (s_r.depth != 6'(ssil_pkg::DEPTH))
					s_nxt.depth = s_r.depth + 6'd1;
				s_nxt.comp = s_r.comp + sig_value; // [R23]
			end
			else if (s_r.depth != 6'd0 && !(recall && s_r.pos == 6'd0)) // [R26]
			begin
				// Swap old for new keeps the sum exact without rescanning
				slot = recall ? ssil_slot(s_r.head, s_r.pos) : s_r.head; // [R17] [R18]
				old = s_r.mem[slot][ssil_pkg::SIG_W-1:0];
				s_nxt.mem[slot] = {s_r.mem[slot][EW-1:ssil_pkg::SIG_W], sig_value}; // [R18]
				s_nxt.comp = s_r.comp - old + sig_value; // [R17]
			end
		end

		if (!recall)
			s_nxt.pos = '0;

		// Clear wipes stack, sum, display and instability, keeps the control register, and aborts a pending measurement
		if (clr)
		begin
			s_nxt.trig = ssil_pkg::TR_IDLE; // [R24]
			s_nxt.busy = 1'b0;
			s_nxt.mem = '0;
			s_nxt.head = '0;
			s_nxt.depth = '0;
			s_nxt.refc = '0;
			s_nxt.pos = '0;
			s_nxt.comp = '0;
			s_nxt.live = '0;
			s_nxt.unst = 1'b0;
			s_nxt.matched = 1'b0;
			s_nxt.prev_ok = 1'b0;
			s_nxt.utmr = '0;
		end

		// Display selection from the freshly computed state
		s_nxt.cled = 1'b0;
		s_nxt.dp = 4'h0;
		s_nxt.dref_on = 1'b0;
		s_nxt.dref = '0;
		if (s_nxt.ctrl[ssil_pkg::CB_RECALL] && s_nxt.pos == 6'd0)
		begin
			s_nxt.dsig = s_nxt.comp;
			s_nxt.cled = 1'b1; // [R1]
			s_nxt.dp = 4'hf; // [R2]
		end
		else if (s_nxt.ctrl[ssil_pkg::CB_RECALL])
		begin
			slot = ssil_slot(s_nxt.head, s_nxt.pos);
			s_nxt.dsig = s_nxt.mem[slot][ssil_pkg::SIG_W-1:0];
			s_nxt.dref = s_nxt.mem[slot][EW-1:ssil_pkg::SIG_W];
			s_nxt.dref_on = 1'b1;
		end
		else
			s_nxt.dsig = s_nxt.live;
	end

	// ==========================================================
	// State register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_r <= '0;
			s_r.ctrl <= ssil_pkg::CTRL_RST;
		end
		else if (ce)
			s_r <= s_nxt;
	end

	// ==========================================================
	// Probe lamp
	assign pif.tip_hi = tip_high;
	assign pif.tip_lo = tip_low;
	assign pif.busy = s_r.busy;
	assign pif.off_req = s_r.off_req;
	assign pif.suspend = self_test; // [R7]

	ssil_probe_ind #(.WIN_CYC(WIN_CYC), .OFF_CYC(OFF_CYC)) u_ind (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.pif(pif)
	);

	// Outputs straight from the state register; the probe lamp straight from the indicator's register
	assign s_axi_awready = s_r.awready;
	assign s_axi_wready = s_r.wready;
	assign s_axi_bvalid = s_r.bvalid;
	assign s_axi_bresp = s_r.bresp;
	assign s_axi_arready = s_r.arready;
	assign s_axi_rvalid = s_r.rvalid;
	assign s_axi_rdata = s_r.rdata;
	assign s_axi_rresp = s_r.rresp;
	assign disp_sig = s_r.dsig;
	assign disp_ref = s_r.dref;
	assign disp_ref_on = s_r.dref_on;
	assign disp_dp = s_r.dp;
	assign composite_led = s_r.cled;
	assign unstable_led = s_r.unst;
	assign probe_led = pif.led;
	assign seg_walk = s_r.walk;
	assign seg_walk_idx = s_r.widx;
	assign sig_offer = s_r.offer;
	assign logic_report = s_r.report;
	assign srq = s_r.srq;

	// ==========================================================
	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// A register write about to execute may carry a clear
	logic wr_clr_seen;
	assign wr_clr_seen = s_r.aw_got && s_r.w_got;

	a_comp_led_dp: assert property (composite_led |-> disp_dp == 4'hf && s_r.ctrl[ssil_pkg::CB_RECALL]) // [R1]
		else $error("composite lamp without marker");
	a_dp_only_comp: assert property (disp_dp != 4'h0 |-> composite_led) // [R2]
		else $error("decimal points without composite");
	a_unst_sets: assert property (ce && sig_done && s_r.prev_ok && sig_value != s_r.prev && !clear_key && !wr_clr_seen
		|=> unstable_led) // [R4]
		else $error("unstable not raised");
	a_unst_min_on: assert property (ce && $rose(unstable_led) |-> s_r.utmr == ssil_pkg::TMR_W'(UNST_CYC - 1)) // [R5]
		else $error("unstable timer not loaded");
	a_unst_latched: assert property (unstable_led && s_r.ctrl[ssil_pkg::CB_ULATCH] && !clear_key
		&& !wr_clr_seen |=> unstable_led) // [R6]
		else $error("latched unstable dropped");
	a_stack_untrig: assert property (s_r.trig != ssil_pkg::TR_MEAS |=> $stable(s_r.comp) || $fell(s_r.comp != 0)
		|| s_r.comp == 0) // [R14]
		else $error("sum changed without trigger");
	a_clear_wipes: assert property (ce && clear_key |=> s_r.depth == 6'd0 && s_r.comp == '0 && !unstable_led) // [R24]
		else $error("clear incomplete");
	a_depth_cap: assert property (s_r.depth <= 6'(ssil_pkg::DEPTH)) // [R21]
		else $error("stack overfull");
	a_busy_bright: assert property (ce && s_r.busy && !self_test ##1 ce && s_r.busy && !self_test |-> probe_led) // [R11]
		else $error("lamp not bright while measuring");
	a_press_arms: assert property (ce && probe_press && !self_test && !s_r.ctrl[ssil_pkg::CB_RECALL]
		&& s_r.trig == ssil_pkg::TR_IDLE && !clear_key && !wr_clr_seen |=> s_r.trig == ssil_pkg::TR_ARMED) // [R13] [R12]
		else $error("press not armed");

	c_trig_push: cover property (s_r.trig == ssil_pkg::TR_MEAS ##1 s_r.depth != 6'd0);
	c_review: cover property (composite_led ##[1:50] disp_ref_on);
	c_walk: cover property ($rose(seg_walk));
endmodule // ssil_top

// [bench/ssil_cut_model.sv]
`timescale 1ns/1ps
// ==========================================================
// Circuit under test: measurement gate, signatures, tip level
module ssil_cut_model (
	input wire logic aclk,
	output logic gate_start,
	output logic sig_done,
	output logic [ssil_pkg::SIG_W-1:0] sig_value,
	output logic tip_high,
	output logic tip_low
);
	// Idle: gate shut, tip steady low
	initial
	begin
		gate_start = 1'b0;
		sig_done = 1'b0;
		sig_value = 16'h0000;
		tip_high = 1'b0;
		tip_low = 1'b1;
	end
	// Gate opening pulse
	task automatic open_gate;
		@(posedge aclk) gate_start <= 1'b1;
		@(posedge aclk) gate_start <= 1'b0;
	endtask
	// Value is only valid with done, so it is inverted afterwards to expose late sampling
	task automatic finish(input logic [ssil_pkg::SIG_W-1:0] v);
		@(posedge aclk) sig_done <= 1'b1;
		sig_value <= v;
		@(posedge aclk) sig_done <= 1'b0;
		sig_value <= ~v;
	endtask
	// One whole gate cycle
	task automatic measure(input logic [ssil_pkg::SIG_W-1:0] v);
		open_gate();
		repeat (2) @(posedge aclk);
		finish(v);
	endtask
	// Tip levels seen by the probe
	task automatic tip(input logic h, input logic l);
		@(posedge aclk) tip_high <= h;
		tip_low <= l;
	endtask
endmodule // ssil_cut_model

// [bench/ssil_top_tb.sv]
`timescale 1ns/1ps
module ssil_top_tb;
	localparam int LIMIT = 20000;
	localparam logic [31:0] SM = 32'h00ff3f00;
	logic aclk, aresetn, ce, ron, awv, wv, br, arv, rr, press, clr, st, rem;
	logic awr, wr, bv, arr, rv, cled, uled, pled, sw, offer, rep, srq, gs, sd, th, tl;
	logic [31:0] aa, ra, wd, rd, v;
	logic [3:0] ws, dp, seen, wsel;
	logic [5:0] widx;
	logic [1:0] bresp, rresp, resp;
	logic [15:0] sv, dsig, sum, t;
	logic [7:0] dref;
	int mismatches, checks_done, cyc, n;
	int lo[4] = '{15, -1, 63, 24};
	int hi[4] = '{17, 1, 65, 40};
	// ==========================================================
	// Clock
	initial
	begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	// ==========================================================
	// Design and far side
	ssil_top #(.WIN_CYC(16), .UNST_CYC(16), .OFF_CYC(8), .STEP_CYC(4)) DUT (
		.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.s_axi_awaddr(aa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
		.s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
		.s_axi_araddr(ra), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp),
		.s_axi_rvalid(rv), .s_axi_rready(rr), .gate_start(gs), .sig_done(sd), .sig_value(sv),
		.probe_press(press), .clear_key(clr), .self_test(st), .remote(rem), .tip_high(th), .tip_low(tl),
		.disp_sig(dsig), .disp_ref(dref), .disp_ref_on(ron), .disp_dp(dp), .composite_led(cled),
		.unstable_led(uled), .probe_led(pled), .seg_walk(sw), .seg_walk_idx(widx), .sig_offer(offer),
		.logic_report(rep), .srq(srq)
	);
	ssil_cut_model cut (.aclk(aclk), .gate_start(gs), .sig_done(sd), .sig_value(sv), .tip_high(th), .tip_low(tl));
	// Timeout, and sticky capture of one-cycle pulses so none is missed
	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == LIMIT)
		begin
			mismatches++;
			complete_run();
		end
		seen <= aresetn ? (seen | {sw, srq, rep, offer}) : 4'h0;
	end
	// ==========================================================
	// Tasks
	task automatic complete_run;
		if (mismatches == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wt(input int k);
		repeat (k) @(posedge aclk);
	endtask
	// Write: address and data offered together, each released once taken
	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ad, dd;
		ad = 1'b0;
		dd = 1'b0;
		aa <= {24'h0, a};
		wd <= d;
		ws <= wsel;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		while (!(ad && dd))
		begin
			@(posedge aclk);
			ad = ad | (awr === 1'b1);
			dd = dd | (wr === 1'b1);
			if (ad) awv <= 1'b0;
			if (dd) wv <= 1'b0;
		end
		do @(posedge aclk); while (bv !== 1'b1);
		// Ready stays up between transfers: each call sets it again and none drops it
		r = bresp;
	endtask
	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		ra <= {24'h0, a};
		arv <= 1'b1;
		rr <= 1'b1;
		do @(posedge aclk); while (arr !== 1'b1);
		arv <= 1'b0;
		do @(posedge aclk); while (rv !== 1'b1);
		d = rd;
		r = rresp;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		axr(a, v, resp);
		chk(v & m, e);
	endtask
	task automatic ctl(input logic [31:0] d);
		axw(ssil_pkg::OFF_CTRL, d, resp);
	endtask
	task automatic prs;
		@(posedge aclk) press <= 1'b1;
		@(posedge aclk) press <= 1'b0;
	endtask
	task automatic trig(input logic [15:0] x);
		prs();
		cut.measure(x);
		wt(10);
	endtask
	// ==========================================================
	// Main sequence
	initial
	begin
		{aresetn, awv, wv, br, arv, rr, press, clr, st, rem} = 10'h0;
		ce = 1'b1;
		wsel = 4'hf;
		{aa, ra, wd, ws} = 100'h0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		wt(2);
		rdc(ssil_pkg::OFF_CTRL, 32'hffffffff, 32'h0);
		rdc(ssil_pkg::OFF_STAT, 32'hffffffff, 32'h0);
		axw(8'h10, 32'h1, resp);
		chk(resp, ssil_pkg::RESP_ERR);
		// Untriggered traffic: instability only, nothing stored
		cut.measure(16'h1234);
		cut.measure(16'h1234);
		wt(20);
		cut.measure(16'h5678);
		wt(2);
		chk(uled, 1'b1);
		cut.measure(16'h5678);
		wt(1);
		chk(uled, 1'b1);
		wt(20);
		chk(uled, 1'b0);
		rdc(ssil_pkg::OFF_STAT, SM, 32'h0);
		rdc(ssil_pkg::OFF_COMP, 32'hffff, 32'h0);
		// Triggered lamp: bright while measuring, off after, then logic again
		prs();
		cut.open_gate();
		wt(2);
		chk(pled, 1'b1);
		cut.tip(1'b1, 1'b0);
		wt(40);
		cut.finish(16'h1111);
		wt(2);
		chk(pled, 1'b0);
		wt(40);
		chk(pled, 1'b1);
		trig(16'hf0f0);
		sum = 16'h1111 + 16'hf0f0;
		rdc(ssil_pkg::OFF_STAT, SM, 32'h00020200);
		rdc(ssil_pkg::OFF_COMP, 32'hffff, sum);
		// Hold mode
		ctl(32'h4);
		cut.measure(16'h0bad);
		wt(2);
		chk(dsig, 16'hf0f0);
		trig(16'h2222);
		chk(dsig, 16'h2222);
		// Edit of newest entry
		ctl(32'h2);
		trig(16'h3333);
		sum = sum + 16'h3333;
		rdc(ssil_pkg::OFF_STAT, SM, 32'h00030300);
		rdc(ssil_pkg::OFF_COMP, 32'hffff, sum);
		// Review, then edit of a reviewed entry
		ctl(32'h1);
		wt(2);
		chk({cled, ron, dp, dsig}, {1'b1, 1'b0, 4'hf, sum});
		prs();
		wt(3);
		chk({cled, ron, dp, dref, dsig}, {1'b0, 1'b1, 4'h0, 8'h03, 16'h3333});
		prs();
		wt(3);
		chk({dref, dsig}, {8'h02, 16'hf0f0});
		ctl(32'h3);
		trig(16'h4444);
		sum = sum - 16'hf0f0 + 16'h4444;
		chk({dref, dsig}, {8'h02, 16'h4444});
		rdc(ssil_pkg::OFF_COMP, 32'hffff, sum);
		ctl(32'h0);
		ctl(32'h3);
		trig(16'h7777);
		rdc(ssil_pkg::OFF_COMP, 32'hffff, sum);
		rdc(ssil_pkg::OFF_STAT, SM, 32'h00030300);
		// Latched instability survives a matching pair, clear removes all
		ctl(32'h8);
		cut.measure(16'h0001);
		cut.measure(16'h0002);
		cut.measure(16'h0002);
		wt(30);
		chk(uled, 1'b1);
		// Clear through byte 1 only: the mode byte must keep the latch
		wsel = 4'h2;
		ctl(32'h100);
		wsel = 4'hf;
		wt(2);
		chk({uled, dsig}, 17'h0);
		rdc(ssil_pkg::OFF_STAT, 32'h00ff3f01, 32'h0);
		rdc(ssil_pkg::OFF_CTRL, 32'hffffffff, 32'h8);
		// Stack overflow and reference wrap past 99
		sum = 16'h0;
		for (int i = 1; i <= 101; i++)
		begin
			t = 16'(i) * 16'h0101;
			trig(t);
			sum = sum + t;
			if (i == 35)
				rdc(ssil_pkg::OFF_STAT, SM, 32'h00352000);
		end
		rdc(ssil_pkg::OFF_STAT, SM, 32'h00012000);
		rdc(ssil_pkg::OFF_COMP, 32'hffff, sum);
		// Remote: offer, logic report, service request
		chk(seen, 4'h0);
		rem <= 1'b1;
		ctl(32'h30);
		trig(16'h5555);
		chk(seen, 4'h7);
		rem <= 1'b0;
		// Self-test lamp walk
		st <= 1'b1;
		prs();
		wt(5);
		chk({sw, widx}, {1'b1, 6'd1});
		// Clock enable low freezes the walk where it stands
		ce <= 1'b0;
		wt(20);
		chk({sw, widx}, {1'b1, 6'd1});
		ce <= 1'b1;
		wt(200);
		chk({seen[3], sw, widx}, {2'b10, 6'(ssil_pkg::NSEG - 1)});
		st <= 1'b0;
		// Clear key
		@(posedge aclk) clr <= 1'b1;
		@(posedge aclk) clr <= 1'b0;
		wt(2);
		rdc(ssil_pkg::OFF_COMP, 32'hffff, 32'h0);
		// Lamp per window: floating, low, high, both
		for (int k = 0; k < 4; k++)
		begin
			cut.tip(k[1], k[0]);
			wt(48);
			n = 0;
			repeat (64) @(posedge aclk) n += (pled === 1'b1);
			chk(n > lo[k] && n < hi[k], 1'b1);
		end
		complete_run();
	end
endmodule // ssil_top_tb
